// ---- dps_pkg.sv ----
// package: register map, field codes and constants for die protection stop
package dps_pkg;

  // =====================================================================
  // sizing
  localparam int NSENS = 8;            // sensor inputs handled
  localparam int CNT_W = 7;            // stroke counter width (holds 99)
  localparam int ANG_W = 9;            // ram angle width, 0..359 degrees

  // =====================================================================
  // limits
  localparam logic [CNT_W-1:0] MAX_STROKES = 7'd99;
  localparam logic [ANG_W-1:0] CRIT_MAX = 9'd184;
  localparam logic [ANG_W-1:0] CRIT_RESET = 9'd185;
  localparam logic [ANG_W-1:0] LOWEST_ANGLE = 9'd180;

  // =====================================================================
  // register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;     // mode, disable command
  localparam logic [7:0] OFS_TOOLCNT = 8'h04;  // tool-wide stroke count
  localparam logic [7:0] OFS_CRIT = 8'h08;     // critical angle
  localparam logic [7:0] OFS_STAT = 8'h0C;     // sticky events, w1c
  localparam logic [7:0] OFS_MASK = 8'h10;     // interrupt mask
  localparam logic [7:0] OFS_ENSTAT = 8'h14;   // enable state, stop outputs
  localparam logic [7:0] OFS_SENS0 = 8'h20;    // per-sensor config base

  // =====================================================================
  // field positions
  localparam int CTRL_MODE_BIT = 0;    // 1 = per-sensor re-enable
  localparam int CTRL_DIS_BIT = 1;     // write 1: disable sensors
  localparam int CTRL_CLR_BIT = 2;     // write 1: clear latched stops
  localparam int STAT_ESTOP_BIT = 0;
  localparam int STAT_TSTOP_BIT = 1;
  localparam int STAT_REEN_BIT = 2;
  localparam int STAT_CRITERR_BIT = 3;
  localparam int STAT_W = 4;
  // sensor config: [1:0] type, [3:2] stop, [10:4] stroke count
  localparam int SC_STOP_LSB = 2;
  localparam int SC_CNT_LSB = 4;

  // =====================================================================
  // encodings
  localparam logic [1:0] TYPE_UNUSED = 2'd0;
  localparam logic [1:0] TYPE_RED = 2'd1;    // fault when input opens
  localparam logic [1:0] TYPE_YELLOW = 2'd2; // fault when input closes
  localparam logic [1:0] TYPE_TIMED = 2'd3;  // must close within window
  localparam logic [1:0] STOP_EMERG = 2'd0;
  localparam logic [1:0] STOP_TOP = 2'd1;
  localparam logic [1:0] STOP_SMART = 2'd2;

endpackage

// ---- dps_reenable.sv ----
// per-sensor re-enable stroke counter
`timescale 1ns/1ps
module dps_reenable
  import dps_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // control
  input wire logic load,               // disable command
  input wire logic [CNT_W-1:0] count,  // strokes until re-enable
  input wire logic stroke,             // one pulse per completed stroke
  // status
  output logic enabled
);

  logic [CNT_W-1:0] remaining; // strokes still to go

  // =====================================================================
  // counter: load on disable, step down per stroke
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      remaining <= 7'd0;
      enabled <= 1'b1;
    end else if (load) begin
      // zero strokes means the disable lasts no stroke at all
      remaining <= count;
      enabled <= (count == 7'd0);
    end else if (stroke && !enabled) begin
      remaining <= remaining - 7'd1;
      if (remaining <= 7'd1) begin
        enabled <= 1'b1;
      end
    end
  end

endmodule

// ---- dps_stop.sv ----
// die protection stop logic with apb registers
//
// Summary of operation
// - stroke counts accepted from 0 to 99
// - tool mode re-enables all after count
// - sensor mode keeps one count per sensor
// - unused sensors never request a stop
// - each sensor has one stop type
// - emergency type halts at once on fault
// - top type latches, halts at stroke top
// - smart between critical angle and lowest point gives top stop
// - smart before critical angle gives emergency
// - critical angle writes only 0..184, 185 refused; reset loads 185
// - one critical angle shared by all sensors
// - timed sensor must close inside window
`timescale 1ns/1ps
module dps_stop
  import dps_pkg::*;
(
  // apb
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // press position
  input wire logic stroke_done,        // pulse, completed stroke
  input wire logic [ANG_W-1:0] ram_angle,
  // sensor pins, high = closed to ground
  input wire logic [NSENS-1:0] sensor_in,
  input wire logic [NSENS-1:0] ready_window, // timed sensor window
  // stop outputs
  output logic estop,
  output logic top_stop,
  output logic irq
);

  // =====================================================================
  // storage
  logic mode_per_input;                 // per_input_reenable_mode
  logic [CNT_W-1:0] tool_count;         // tool_wide_reenable_mode count
  logic [ANG_W-1:0] crit_angle;         // shared by all smart sensors
  logic [10:0] scfg [NSENS];            // per sensor configuration
  logic [STAT_W-1:0] stat;              // sticky events
  logic [STAT_W-1:0] mask;
  logic estop_lat;                      // emergency request latched
  logic top_pend;                       // top stop awaiting top
  logic [NSENS-1:0] s1, s2;             // sensor synchroniser
  logic [NSENS-1:0] w1, w2;             // window synchroniser
  logic [NSENS-1:0] w_d;                // window, one cycle late
  logic [NSENS-1:0] seen;               // timed sensor closed in window
  logic [NSENS-1:0] sens_en;            // per sensor enable state
  logic tool_en;
  logic [NSENS-1:0] fault;
  logic [NSENS-1:0] want_e, want_t;
  logic wr, rd, dis_cmd, clr_cmd;
  logic [STAT_W-1:0] ev;
  logic reen_ev;
  logic crit_bad;

  // =====================================================================
  // apb decode: zero wait states, unmapped reads zero with error
  assign wr = psel && penable && pwrite;
  assign rd = psel && !pwrite;
  assign pready = 1'b1;
  assign dis_cmd = wr && paddr == OFS_CTRL && pwdata[CTRL_DIS_BIT];
  assign clr_cmd = wr && paddr == OFS_CTRL && pwdata[CTRL_CLR_BIT];
  // angle 185 or beyond is refused and flagged
  assign crit_bad = wr && paddr == OFS_CRIT
    && pwdata[ANG_W-1:0] > CRIT_MAX;

  always_comb begin
    pslverr = 1'b0;
    if (psel && penable) begin
      if (!(paddr inside {OFS_CTRL, OFS_TOOLCNT, OFS_CRIT, OFS_STAT,
          OFS_MASK, OFS_ENSTAT}) &&
          !(paddr >= OFS_SENS0 && paddr < OFS_SENS0 + 8'(4 * NSENS))) begin
        pslverr = 1'b1;
      end
    end
  end

  // read data registered in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (rd && !penable) begin
      case (paddr)
        OFS_CTRL: prdata <= {31'h0, mode_per_input};
        OFS_TOOLCNT: prdata <= {25'h0, tool_count};
        OFS_CRIT: prdata <= {23'h0, crit_angle};
        OFS_STAT: prdata <= {28'h0, stat};
        OFS_MASK: prdata <= {28'h0, mask};
        OFS_ENSTAT: prdata <= {14'h0, estop, top_stop, tool_en,
          7'h0, sens_en};
        default: begin
          if (paddr >= OFS_SENS0 && paddr < OFS_SENS0 + 8'(4 * NSENS)) begin
            prdata <= {21'h0, scfg[3'(paddr[4:2])]};
          end else begin
            prdata <= 32'h0000_0000;
          end
        end
      endcase
    end
  end

  // =====================================================================
  // configuration writes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_per_input <= 1'b0;
      tool_count <= 7'd0;
      crit_angle <= CRIT_RESET;
      mask <= 4'h0;
    end else if (wr) begin
      case (paddr)
        OFS_CTRL: mode_per_input <= pwdata[CTRL_MODE_BIT];
        // counts over 99 are clipped, never stored
        OFS_TOOLCNT: tool_count <= (pwdata[6:0] > MAX_STROKES ||
          pwdata[31:7] != 25'h0) ? MAX_STROKES : pwdata[6:0];
        OFS_CRIT: begin
          if (!crit_bad) begin
            crit_angle <= pwdata[ANG_W-1:0];
          end
        end
        OFS_MASK: mask <= pwdata[STAT_W-1:0];
        default: begin
        end
      endcase
    end
  end

  // =====================================================================
  // per sensor config, one word each
  genvar gi;
  generate
    for (gi = 0; gi < NSENS; gi++) begin : g_cfg
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          scfg[gi] <= 11'h000;
        end else if (wr && paddr == OFS_SENS0 + 8'(4 * gi)) begin
          // a single stop type per sensor; code 3 reads as emergency
          scfg[gi][3:0] <= pwdata[3:0];
          scfg[gi][10:4] <= (pwdata[10:4] > MAX_STROKES) ?
            MAX_STROKES : pwdata[10:4];
        end
      end
      // per sensor re-enable counter
      dps_reenable u_re (
        .pclk(pclk),
        .presetn(presetn),
        .load(dis_cmd && mode_per_input),
        .count(scfg[gi][10:4]),
        .stroke(stroke_done),
        .enabled(sens_en[gi])
      );
    end
  endgenerate

  // tool-wide counter shares the same counter design
  dps_reenable u_tool (
    .pclk(pclk),
    .presetn(presetn),
    .load(dis_cmd && !mode_per_input),
    .count(tool_count),
    .stroke(stroke_done),
    .enabled(tool_en)
  );

  // =====================================================================
  // synchronisers for pin inputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1 <= '0;
      s2 <= '0;
      w1 <= '0;
      w2 <= '0;
      w_d <= '0;
    end else begin
      s1 <= sensor_in;
      s2 <= s1;
      w1 <= ready_window;
      w2 <= w1;
      w_d <= w2;
    end
  end

  // =====================================================================
  // fault detection per sensor
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      seen <= '0;
    end else begin
      for (int i = 0; i < NSENS; i++) begin
        if (w2[i] && !w_d[i]) begin
          seen[i] <= s2[i];     // window opens
        end else if (w2[i] && s2[i]) begin
          seen[i] <= 1'b1;
        end
      end
    end
  end

  always_comb begin
    for (int i = 0; i < NSENS; i++) begin
      case (scfg[i][1:0])
        TYPE_RED: fault[i] = !s2[i];
        TYPE_YELLOW: fault[i] = s2[i];
        // window closes without a closure to ground
        TYPE_TIMED: fault[i] = w_d[i] && !w2[i] && !seen[i];
        default: fault[i] = 1'b0;
      endcase
      // disabled sensors are silent until re-enabled
      if (!sens_en[i] || !tool_en) begin
        fault[i] = 1'b0;
      end
    end
  end

  // stop kind per sensor; smart split by critical angle and lowest point
  always_comb begin
    for (int i = 0; i < NSENS; i++) begin
      want_e[i] = 1'b0;
      want_t[i] = 1'b0;
      case (scfg[i][3:2])
        STOP_TOP: want_t[i] = fault[i];
        STOP_SMART: begin
          if (ram_angle > crit_angle && ram_angle < LOWEST_ANGLE) begin
            want_t[i] = fault[i];
          end else begin
            want_e[i] = fault[i];
          end
        end
        default: want_e[i] = fault[i];
      endcase
    end
  end

  // =====================================================================
  // stop latches; a new fault wins over a clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      estop_lat <= 1'b0;
      top_pend <= 1'b0;
      top_stop <= 1'b0;
    end else begin
      if (|want_e) begin
        estop_lat <= 1'b1;
      end else if (clr_cmd) begin
        estop_lat <= 1'b0;
      end
      if (|want_t) begin
        top_pend <= 1'b1;
      end else if (clr_cmd) begin
        top_pend <= 1'b0;
      end
      // top of stroke is the completed stroke pulse
      if (top_pend && stroke_done) begin
        top_stop <= 1'b1;
      end else if (clr_cmd && !(|want_t)) begin
        top_stop <= 1'b0;
      end
    end
  end

  // halt with no wait for latching
  assign estop = estop_lat || (|want_e);

  // =====================================================================
  // interrupts: sticky w1c, set wins over clear
  assign reen_ev = 1'b0 | (stroke_done && !tool_en);
  assign ev = {crit_bad, reen_ev, |want_t, |want_e};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stat <= 4'h0;
    end else if (wr && paddr == OFS_STAT) begin
      stat <= (stat & ~pwdata[STAT_W-1:0]) | ev;
    end else begin
      stat <= stat | ev;
    end
  end

  assign irq = |(stat & mask);

endmodule

// ---- dps_stop_props.sv ----
// assertions on the ports of the die protection stop block
`timescale 1ns/1ps
module dps_stop_props
  import dps_pkg::*;
(
  // apb
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // press and stops
  input wire logic stroke_done,
  input wire logic estop,
  input wire logic top_stop
);
  // ==========
  // helpers
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic clr_wr; // clear command taken this edge
  assign clr_wr = psel && penable && pwrite && paddr == OFS_CTRL
    && pwdata[CTRL_CLR_BIT];
  // ==========
  // bus behaviour
  AST_READY: assert property (psel && penable |-> pready)
    else $error("access phase without ready");
  AST_UNMAPPED: assert property (psel && penable && paddr == 8'h18 |-> pslverr)
    else $error("unmapped access not flagged");
  AST_SLV_PHASE: assert property (pslverr |-> psel && penable)
    else $error("error flag outside access phase");
  AST_MAPPED: assert property (
    psel && penable && paddr == OFS_CRIT |-> !pslverr)
    else $error("mapped access flagged");
  AST_RD_HOLD: assert property (psel && penable && !pwrite |=> $stable(prdata))
    else $error("read data moved after access");
  // ==========
  // stop outputs; latches hold until a clear
  AST_EST_HOLD: assert property (estop && !clr_wr |=> estop)
    else $error("emergency stop dropped without clear");
  AST_TOP_HOLD: assert property (top_stop && !clr_wr |=> top_stop)
    else $error("top stop dropped without clear");
  AST_TOP_AT_TOP: assert property (
    $rose(top_stop) |-> $past(stroke_done))
    else $error("top stop not at top of stroke");
endmodule

// ---- dps_press_model.sv ----
// press model: ram angle, stroke pulse, sensor pins, ready window
`timescale 1ns/1ps
module dps_press_model
  import dps_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // bench control
  input wire logic run,
  input wire logic [NSENS-1:0] fault,
  // toward the block
  output logic stroke_done,
  output logic [ANG_W-1:0] ram_angle,
  output logic [NSENS-1:0] sensor_in,
  output logic [NSENS-1:0] ready_window
);
  // pin 0 is a red sensor resting closed, the rest rest open
  localparam logic [NSENS-1:0] REST = 8'h01;
  // ==========
  // ram motion, 4 degrees a cycle keeps strokes short
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ram_angle <= '0;
      stroke_done <= 1'b0;
    end else begin
      // wrap is the top of stroke
      stroke_done <= run && ram_angle == 9'h164;
      if (run) begin
        ram_angle <= (ram_angle == 9'h164) ? '0 : ram_angle + 9'h004;
      end
    end
  end
  // timed window 100..160 degrees for every pin
  assign ready_window =
    {NSENS{ram_angle >= 9'h064 && ram_angle <= 9'h0a0}};
  // a fault flips the pin away from rest
  assign sensor_in = REST ^ fault;
endmodule

// ---- tb_dps_stop.sv ----
// testbench for the die protection stop block
`timescale 1ns/1ps
module tb_dps_stop
  import dps_pkg::*;
;
  // ==========
  // signals
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, q;
  logic pready, pslverr, stroke_done, estop, top_stop, irq, se, run = 0;
  logic [ANG_W-1:0] ram_angle;
  logic [NSENS-1:0] sensor_in, ready_window, fault = '0;
  int bad_count = 0, n_tests = 0, cyc = 0;
  always #2.5 pclk = ~pclk;
  dps_stop dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .stroke_done, .ram_angle, .sensor_in,
    .ready_window, .estop, .top_stop, .irq);
  dps_press_model press (.pclk, .presetn, .run, .fault, .stroke_done,
    .ram_angle, .sensor_in, .ready_window);
  // ==========
  // tasks
  task automatic end_sim;
    $display("checks %0d errors %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, g);
    n_tests++;
    if (g !== e) begin
      bad_count++;
      $display("CHECK FAILED %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic cf(input string n, input logic e, g);
    chk(n, {31'h0, e}, {31'h0, g});
  endtask
  // one apb transfer; an idle cycle after keeps psel edges apart
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk) penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    se = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge pclk);
  endtask
  task automatic rc(input string n, input logic [7:0] a,
                    input logic [31:0] m, e);
    bus(0, a, 32'h0000_0000);
    chk(n, e, q & m);
  endtask
  task automatic at(input logic [ANG_W-1:0] x);
    while (ram_angle !== x) @(posedge pclk);
  endtask
  // top_stop lands one edge after the stroke pulse
  task automatic strokes(input int n);
    repeat (n) @(posedge stroke_done);
    repeat (2) @(posedge pclk);
  endtask
  // drop the fault, let the synchroniser settle, clear latches
  task automatic clr;
    fault <= '0;
    repeat (3) @(posedge pclk);
    bus(1, OFS_CTRL, 32'h0000_0004);
    bus(1, OFS_STAT, 32'h0000_000f);
  endtask
  // ==========
  // hang guard
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 5000) begin
      bad_count++;
      end_sim();
    end
  end
  // ==========
  // main sequence
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    rc("crit_rst", OFS_CRIT, '1, 32'h0000_00b9);
    // enable word: [7:0] sensors, [15] tool, [16] top stop, [17] estop
    rc("en_rst", OFS_ENSTAT, 32'h0003_80ff, 32'h0000_80ff);
    bus(1, OFS_CRIT, 32'h0000_00b8);
    bus(1, OFS_CRIT, 32'h0000_00b9);
    rc("crit", OFS_CRIT, '1, 32'h0000_00b8);
    rc("crit_err", OFS_STAT, 32'h0000_0008, 32'h0000_0008);
    bus(1, OFS_TOOLCNT, 32'h0000_0078);
    rc("tcnt", OFS_TOOLCNT, 32'h0000_007f, 32'h0000_0063);
    rc("unmapped", 8'h18, '1, 32'h0000_0000);
    cf("slverr", 1'b1, se);
    // sensor 0 red emergency, 1 yellow top, 2 yellow smart
    bus(1, OFS_MASK, 32'h0000_0001);
    bus(1, OFS_SENS0, 32'h0000_0001);
    bus(1, OFS_SENS0 + 8'h04, 32'h0000_0006);
    bus(1, OFS_SENS0 + 8'h08, 32'h0000_000a);
    rc("scfg", OFS_SENS0 + 8'h08, '1, 32'h0000_000a);
    fault <= 8'h08;
    repeat (4) @(posedge pclk);
    cf("unused", 1'b0, estop | top_stop);
    fault <= 8'h01;
    repeat (4) @(posedge pclk);
    cf("estop", 1'b1, estop);
    cf("irq", 1'b1, irq);
    clr();
    cf("irq_clr", 1'b0, irq);
    cf("est_clr", 1'b0, estop);
    run <= 1;
    at(9'h028);
    fault <= 8'h02;
    repeat (4) @(posedge pclk);
    cf("top_wait", 1'b0, estop | top_stop);
    strokes(1);
    cf("top", 1'b1, top_stop);
    cf("irq_mask", 1'b0, irq);
    clr();
    // smart stop around a 90 degree critical angle
    bus(1, OFS_CRIT, 32'h0000_005a);
    at(9'h078);
    fault <= 8'h04;
    repeat (4) @(posedge pclk);
    cf("smart_e0", 1'b0, estop);
    // drop the fault so it is not seen again past the lowest point
    fault <= '0;
    strokes(1);
    cf("smart_top", 1'b1, top_stop);
    cf("smart_e1", 1'b0, estop);
    clr();
    at(9'h0c8);
    fault <= 8'h04;
    repeat (4) @(posedge pclk);
    cf("smart_emg", 1'b1, estop);
    clr();
    // tool-wide re-enable after two strokes
    bus(1, OFS_TOOLCNT, 32'h0000_0002);
    at(9'h064);
    bus(1, OFS_CTRL, 32'h0000_0002);
    // tool mode drops only the tool enable, sensor enables stay up
    rc("tool_off", OFS_ENSTAT, 32'h0000_80ff, 32'h0000_00ff);
    fault <= 8'h01;
    repeat (4) @(posedge pclk);
    cf("silent", 1'b0, estop);
    fault <= '0;
    strokes(1);
    rc("tool_one", OFS_ENSTAT, 32'h0000_80ff, 32'h0000_00ff);
    strokes(1);
    rc("tool_on", OFS_ENSTAT, 32'h0000_80ff, 32'h0000_80ff);
    // per-sensor counts of one and three strokes
    bus(1, OFS_SENS0, 32'h0000_0011);
    bus(1, OFS_SENS0 + 8'h04, 32'h0000_0036);
    // mode is a stored bit: set it before the disable that relies on it
    bus(1, OFS_CTRL, 32'h0000_0001);
    at(9'h064);
    bus(1, OFS_CTRL, 32'h0000_0003);
    rc("ps_off", OFS_ENSTAT, 32'h0000_0003, 32'h0000_0000);
    strokes(1);
    rc("ps_one", OFS_ENSTAT, 32'h0000_0003, 32'h0000_0001);
    strokes(2);
    rc("ps_three", OFS_ENSTAT, 32'h0000_0003, 32'h0000_0003);
    // timed sensor 4 never closes inside its window
    at(9'h0c8);
    bus(1, OFS_SENS0 + 8'h10, 32'h0000_0003);
    at(9'h078);
    cf("timed_in", 1'b0, estop);
    at(9'h0b4);
    cf("timed", 1'b1, estop);
    end_sim();
  end
endmodule
bind dps_stop dps_stop_props u_props (.pclk, .presetn, .psel, .penable,
  .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .stroke_done,
  .estop, .top_stop);
